// *** rtl/sqc_regs.svh ***
// Register offsets, reset values and timing counts for storm/QoS config
`ifndef SQC_REGS_SVH
`define SQC_REGS_SVH
`define SQC_OFS_STORM_HIGH 8'h06
`define SQC_OFS_STORM_LOW 8'h07
`define SQC_OFS_TEST_A 8'h08
`define SQC_OFS_TEST_B 8'h09
`define SQC_OFS_TEST_C 8'h0a
`define SQC_OFS_HOST_CLK 8'h0b
`define SQC_OFS_MAP_LOW 8'h0c
`define SQC_OFS_MAP_HIGH 8'h0d
`define SQC_RST_STORM_HIGH 3'h0
`define SQC_RST_STORM_LOW 8'h63
`define SQC_RST_TEST_A 8'h00
`define SQC_RST_TEST_B 8'h24
`define SQC_RST_TEST_C 8'h35
`define SQC_RST_CLK_SEL 2'h2
`define SQC_RST_CLK_RSVD 6'h08
`define SQC_RST_MAP_LOW 8'h50
`define SQC_RST_MAP_HIGH 8'hfa
`define SQC_CLK_SEL_LSB 6
`define SQC_LIMIT_W 11
`define SQC_CLK_PERIOD_NS 10
`define SQC_PERIOD_FAST_MS 67
`define SQC_PERIOD_SLOW_MS 500
`define SQC_PERIOD_FAST_CYC \
  (`SQC_PERIOD_FAST_MS * 1000000 / `SQC_CLK_PERIOD_NS)
`define SQC_PERIOD_SLOW_CYC \
  (`SQC_PERIOD_SLOW_MS * 1000000 / `SQC_CLK_PERIOD_NS)
`endif

// *** rtl/sqc_pkg.sv ***
// Types shared by the storm/QoS configuration block
package sqc_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sqc_req_t;
  typedef enum logic [1:0] {
    SQC_CLK_31M = 2'h0,
    SQC_CLK_62M = 2'h1,
    SQC_CLK_125M = 2'h2
  } sqc_clk_sel_t;
endpackage

// *** rtl/sqc_top.sv ***
// Global storm limit, factory test, host clock and 802.1p map registers
//
// Contract
// - Storm limit is upper 3 bits joined with low 8 bits, in 64-byte blocks.
// - Metering period is 67 ms at 100 Mbps, 500 ms at 10 Mbps.
// - Low storm rate field resets to 0x63.
// - Limit applies per input port over each period.
// - Test registers 0x08-0x0A are read-only: 0x00, 0x24, 0x35.
// - Bits 7-6 of 0x0B select host clock 31.25/62.5/125 MHz, reset 10.
// - Tagged frame priority comes from the 2-bit field indexed by the tag.
// - Register 0x0C holds tags 0..3 in bits 1-0, 3-2, 5-4, 7-6.
// - Tags 0 and 1 reset to 00, tags 2 and 3 to 01.
// - Register 0x0D bits 7-6 tag 7, bits 5-4 tag 6, reset 11.
// - Bits 5-0 of 0x0B are read-only, reading 00,10,0,0.
// - Upper storm limit bits sit in 0x06 bits 2-0, reset 000.
// - Register 0x0D bits 3-2 tag 5, bits 1-0 tag 4, reset 10.
`timescale 1ns/1ps
`include "sqc_regs.svh"
module sqc_top #(
  parameter int NPORTS = 3,
  parameter int FAST_CYC = `SQC_PERIOD_FAST_CYC,
  parameter int SLOW_CYC = `SQC_PERIOD_SLOW_CYC
) (
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  input wire sqc_pkg::sqc_req_t REG_REQ_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic [NPORTS-1:0] BCAST_BLK_I,
  input wire logic [NPORTS-1:0] PORT_10M_I,
  output logic [NPORTS-1:0] STORM_PASS_O,
  output logic [NPORTS-1:0] STORM_DROP_O,
  input wire logic TAG_VALID_I,
  input wire logic [2:0] TAG_I,
  output logic PRIO_VALID_O,
  output logic [1:0] PRIO_O,
  output sqc_pkg::sqc_clk_sel_t HOST_CLK_SEL_O
);

  function automatic logic [1:0] map_field(input logic [7:0] lo,
                                           input logic [7:0] hi,
                                           input logic [2:0] tag);
    logic [15:0] m;
    m = {hi, lo};
    return m[{tag, 1'b0} +: 2];
  endfunction

  // Register file
  logic [2:0] storm_high_r, storm_high_nxt;
  logic [7:0] storm_low_r, storm_low_nxt;
  sqc_pkg::sqc_clk_sel_t clk_sel_nxt;
  logic [7:0] map_low_r, map_low_nxt;
  logic [7:0] map_high_r, map_high_nxt;
  logic [7:0] rdata_nxt;
  logic [`SQC_LIMIT_W-1:0] limit;

  assign limit = {storm_high_r, storm_low_r};

  always_comb begin
    storm_high_nxt = storm_high_r;
    storm_low_nxt = storm_low_r;
    clk_sel_nxt = HOST_CLK_SEL_O;
    map_low_nxt = map_low_r;
    map_high_nxt = map_high_r;
    rdata_nxt = REG_RDATA_O;
    // Writes to read-only offsets and reserved bits are simply dropped
    if (REG_REQ_I.wr) begin
      unique case (REG_REQ_I.addr)
        `SQC_OFS_STORM_HIGH: storm_high_nxt = REG_REQ_I.wdata[2:0];
        `SQC_OFS_STORM_LOW: storm_low_nxt = REG_REQ_I.wdata;
        `SQC_OFS_HOST_CLK: clk_sel_nxt = sqc_pkg::sqc_clk_sel_t'(
          REG_REQ_I.wdata[`SQC_CLK_SEL_LSB +: 2]);
        `SQC_OFS_MAP_LOW: map_low_nxt = REG_REQ_I.wdata;
        `SQC_OFS_MAP_HIGH: map_high_nxt = REG_REQ_I.wdata;
        default: ;
      endcase
    end
    if (REG_REQ_I.rd) begin
      unique case (REG_REQ_I.addr)
        `SQC_OFS_STORM_HIGH: rdata_nxt = {5'h00, storm_high_r};
        `SQC_OFS_STORM_LOW: rdata_nxt = storm_low_r;
        `SQC_OFS_TEST_A: rdata_nxt = `SQC_RST_TEST_A;
        `SQC_OFS_TEST_B: rdata_nxt = `SQC_RST_TEST_B;
        `SQC_OFS_TEST_C: rdata_nxt = `SQC_RST_TEST_C;
        `SQC_OFS_HOST_CLK: rdata_nxt = {HOST_CLK_SEL_O,
                                       `SQC_RST_CLK_RSVD};
        `SQC_OFS_MAP_LOW: rdata_nxt = map_low_r;
        `SQC_OFS_MAP_HIGH: rdata_nxt = map_high_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      storm_high_r <= `SQC_RST_STORM_HIGH;
      storm_low_r <= `SQC_RST_STORM_LOW;
      HOST_CLK_SEL_O <= sqc_pkg::SQC_CLK_125M;
      map_low_r <= `SQC_RST_MAP_LOW;
      map_high_r <= `SQC_RST_MAP_HIGH;
      REG_RDATA_O <= 8'h00;
    end else begin
      storm_high_r <= storm_high_nxt;
      storm_low_r <= storm_low_nxt;
      HOST_CLK_SEL_O <= clk_sel_nxt;
      map_low_r <= map_low_nxt;
      map_high_r <= map_high_nxt;
      REG_RDATA_O <= rdata_nxt;
    end
  end

  // Priority lookup, one cycle latency
  logic prio_valid_nxt;
  logic [1:0] prio_nxt;

  always_comb begin
    prio_valid_nxt = TAG_VALID_I;
    prio_nxt = TAG_VALID_I ? map_field(map_low_r, map_high_r, TAG_I)
                           : PRIO_O;
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      PRIO_VALID_O <= 1'b0;
      PRIO_O <= 2'h0;
    end else begin
      PRIO_VALID_O <= prio_valid_nxt;
      PRIO_O <= prio_nxt;
    end
  end

  // Storm metering, one period timer per port since speeds differ
  logic [31:0] per_cnt_r [NPORTS];
  logic [31:0] per_cnt_nxt [NPORTS];
  logic [`SQC_LIMIT_W-1:0] blk_cnt_r [NPORTS];
  logic [`SQC_LIMIT_W-1:0] blk_cnt_nxt [NPORTS];
  logic [NPORTS-1:0] per_end;
  logic [NPORTS-1:0] pass_nxt;
  logic [NPORTS-1:0] drop_nxt;

  always_comb begin
    for (int p = 0; p < NPORTS; p++) begin
      // Compare with >= so a speed change mid-period cannot overrun
      per_end[p] = PORT_10M_I[p] ? (per_cnt_r[p] >= 32'(SLOW_CYC - 1))
                                 : (per_cnt_r[p] >= 32'(FAST_CYC - 1));
      per_cnt_nxt[p] = per_end[p] ? 32'h0 : per_cnt_r[p] + 32'h1;
      blk_cnt_nxt[p] = per_end[p] ? '0 : blk_cnt_r[p];
      pass_nxt[p] = 1'b0;
      drop_nxt[p] = 1'b0;
      if (BCAST_BLK_I[p]) begin
        if (per_end[p]) begin
          // A block on the boundary opens the new period
          pass_nxt[p] = (limit != '0);
          drop_nxt[p] = (limit == '0);
          blk_cnt_nxt[p] = (limit != '0) ? `SQC_LIMIT_W'(1) : '0;
        end else if (blk_cnt_r[p] < limit) begin
          pass_nxt[p] = 1'b1;
          blk_cnt_nxt[p] = blk_cnt_r[p] + `SQC_LIMIT_W'(1);
        end else begin
          drop_nxt[p] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      for (int p = 0; p < NPORTS; p++) begin
        per_cnt_r[p] <= 32'h0;
        blk_cnt_r[p] <= '0;
      end
      STORM_PASS_O <= '0;
      STORM_DROP_O <= '0;
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        per_cnt_r[p] <= per_cnt_nxt[p];
        blk_cnt_r[p] <= blk_cnt_nxt[p];
      end
      STORM_PASS_O <= pass_nxt;
      STORM_DROP_O <= drop_nxt;
    end
  end

  // Checks
  for (genvar g = 0; g < NPORTS; g++) begin : g_chk
    sequence s_over;
      BCAST_BLK_I[g] && !per_end[g] && blk_cnt_r[g] >= limit;
    endsequence
    sequence s_under;
      BCAST_BLK_I[g] && !per_end[g] && blk_cnt_r[g] < limit;
    endsequence
    a_drop_over_limit:
      assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
        s_over |=> STORM_DROP_O[g] && !STORM_PASS_O[g])
      else $error("block over limit not dropped");
    a_pass_under_limit:
      assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
        s_under |=> STORM_PASS_O[g] && blk_cnt_r[g] == $past(blk_cnt_r[g]) + 1)
      else $error("block under limit not admitted");
    a_period_restart:
      assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
        per_end[g] |=> per_cnt_r[g] == 32'h0 && blk_cnt_r[g] <= 1)
      else $error("period end did not restart counts");
    a_period_bound:
      assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
        per_cnt_r[g] < 32'(SLOW_CYC))
      else $error("period timer overran");
  end

  a_test_reg_b:
    assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
      REG_REQ_I.rd && REG_REQ_I.addr == `SQC_OFS_TEST_B
      |=> REG_RDATA_O == 8'h24)
    else $error("factory test register b wrong");
  a_clk_sel_write:
    assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
      REG_REQ_I.wr && REG_REQ_I.addr == `SQC_OFS_HOST_CLK
      |=> HOST_CLK_SEL_O == $past(REG_REQ_I.wdata[7:6]))
    else $error("host clock select not written");
  a_reserved_ro:
    assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
      REG_REQ_I.rd && REG_REQ_I.addr == `SQC_OFS_HOST_CLK
      |=> REG_RDATA_O[5:0] == 6'h08)
    else $error("reserved host clock bits wrong");
  a_prio_lookup:
    assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
      TAG_VALID_I && !REG_REQ_I.wr |=> PRIO_VALID_O &&
      PRIO_O == map_field(map_low_r, map_high_r, $past(TAG_I)))
    else $error("priority lookup wrong");
  a_map_low_layout:
    assert property (@(posedge CLOCK_I) disable iff (!RESETN_I)
      REG_REQ_I.rd && REG_REQ_I.addr == `SQC_OFS_MAP_LOW && !REG_REQ_I.wr
      |=> REG_RDATA_O[7:6] == map_field(map_low_r, map_high_r, 3'h3))
    else $error("tag map layout wrong");

endmodule

// *** sim/tb.sv ***
// Self-checking bench for the storm limit, clock select and tag map block
`timescale 1ns/1ps
module tb;
  localparam int NF = 20;
  localparam int NS = 50;
  logic CLOCK_I = 0;
  logic RESETN_I = 0;
  sqc_pkg::sqc_req_t REG_REQ_I = '0;
  logic [7:0] REG_RDATA_O;
  logic [2:0] BCAST_BLK_I = '0;
  logic [2:0] PORT_10M_I = 3'h2;
  logic [2:0] STORM_PASS_O;
  logic [2:0] STORM_DROP_O;
  logic TAG_VALID_I = 0;
  logic [2:0] TAG_I = '0;
  logic PRIO_VALID_O;
  logic [1:0] PRIO_O;
  sqc_pkg::sqc_clk_sel_t HOST_CLK_SEL_O;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [7:0] lfsr = 8'h58;
  logic [7:0] mdl [8] = '{8'h00, 8'h63, 8'h00, 8'h24, 8'h35, 8'h88, 8'h50,
                          8'hfa};
  // Writable bits per offset 0x06..0x0d
  logic [7:0] msk [8] = '{8'h07, 8'hff, 8'h00, 8'h00, 8'h00, 8'hc0, 8'hff,
                          8'hff};

  sqc_top #(.NPORTS(3), .FAST_CYC(NF), .SLOW_CYC(NS)) dut_u (
    .CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I), .REG_REQ_I(REG_REQ_I),
    .REG_RDATA_O(REG_RDATA_O), .BCAST_BLK_I(BCAST_BLK_I),
    .PORT_10M_I(PORT_10M_I), .STORM_PASS_O(STORM_PASS_O),
    .STORM_DROP_O(STORM_DROP_O), .TAG_VALID_I(TAG_VALID_I), .TAG_I(TAG_I),
    .PRIO_VALID_O(PRIO_VALID_O), .PRIO_O(PRIO_O),
    .HOST_CLK_SEL_O(HOST_CLK_SEL_O));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction

  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge CLOCK_I);
    REG_REQ_I <= sqc_pkg::sqc_req_t'({w, ~w, a, d});
    @(posedge CLOCK_I);
    REG_REQ_I <= '0;
    #1;
    if (w && a >= 8'h06 && a <= 8'h0d)
      mdl[a-6] = (mdl[a-6] & ~msk[a-6]) | (d & msk[a-6]);
  endtask

  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] e;
    e = (a >= 8'h06 && a <= 8'h0d) ? mdl[a-6] : 8'h00;
    acc(1'b0, a, 8'h00);
    chk(REG_RDATA_O, e, "rd");
  endtask

  task automatic look(input logic [2:0] t);
    logic [15:0] m;
    m = {mdl[7], mdl[6]};
    @(posedge CLOCK_I);
    TAG_VALID_I <= 1'b1;
    TAG_I <= t;
    @(posedge CLOCK_I);
    TAG_VALID_I <= 1'b0;
    #1;
    chk({7'h0, PRIO_VALID_O}, 8'h01, "prio valid");
    chk(8'(PRIO_O), 8'(m[2*t +: 2]), "prio");
  endtask

  // Locks onto the period phase at the first pass after a drop
  task automatic storm(input int cyc, input int lim);
    int cnt[3];
    int ph[3];
    bit sy[3];
    logic pd[3];
    logic ex;
    bit free;
    cnt = '{0, 0, 0};
    ph = '{0, 0, 0};
    sy = '{0, 0, 0};
    pd = '{0, 0, 0};
    free = lim == 0 || lim > 200;
    @(posedge CLOCK_I);
    BCAST_BLK_I <= 3'h7;
    @(posedge CLOCK_I);
    repeat (cyc) begin
      @(posedge CLOCK_I);
      #1;
      for (int p = 0; p < 3; p++) begin
        if (!sy[p] && !free && pd[p] && STORM_PASS_O[p]) begin
          sy[p] = 1;
          cnt[p] = 1;
          ph[p] = 0;
        end else if (sy[p] || free) begin
          ph[p] = (ph[p] + 1) % (PORT_10M_I[p] ? NS : NF);
          if (ph[p] == 0) cnt[p] = 0;
          ex = cnt[p] < lim;
          if (ex) cnt[p]++;
          chk(8'(STORM_PASS_O[p]), 8'(ex), "pass");
        end
        chk({7'h0, STORM_PASS_O[p] ^ STORM_DROP_O[p]}, 8'h01, "ans");
        pd[p] = STORM_DROP_O[p];
      end
    end
    @(posedge CLOCK_I);
    BCAST_BLK_I <= 3'h0;
    // A port that never locked would have skipped every pass check
    for (int p = 0; p < 3; p++) begin
      if (!free) chk(8'(sy[p]), 8'h01, "lock");
    end
  endtask

  task automatic summarize();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    forever #5 CLOCK_I = ~CLOCK_I;
  end

  // Whole run needs about 370 cycles
  always @(posedge CLOCK_I) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    repeat (16) @(posedge CLOCK_I);
    chk({6'h0, HOST_CLK_SEL_O}, 8'h02, "clk rst");
    RESETN_I <= 1'b1;
    for (int a = 6; a < 14; a++) rd_chk(8'(a));
    rd_chk(8'h20);
    for (int t = 0; t < 8; t++) look(3'(t));
    $display("test reset values done");
    for (int a = 6; a < 14; a++) acc(1'b1, 8'(a), a == 11 ? 8'h3f : 8'hff);
    acc(1'b1, 8'h20, 8'hff);
    for (int a = 6; a < 14; a++) rd_chk(8'(a));
    for (int v = 0; v < 3; v++) begin
      acc(1'b1, 8'h0b, {2'(v), 6'(rnd())});
      chk({6'h0, HOST_CLK_SEL_O}, 8'(v), "clk sel");
      rd_chk(8'h0b);
    end
    // Host settles on the slowest clock its link allows, to save power
    acc(1'b1, 8'h0b, 8'h00);
    chk({6'h0, HOST_CLK_SEL_O}, 8'h00, "clk low");
    repeat (2) begin
      acc(1'b1, 8'h0c, rnd());
      acc(1'b1, 8'h0d, rnd());
      for (int t = 0; t < 8; t++) look(3'(t));
    end
    $display("test register access done");
    acc(1'b1, 8'h06, 8'h00);
    acc(1'b1, 8'h07, 8'h03);
    storm(150, 3);
    acc(1'b1, 8'h07, 8'h00);
    storm(30, 0);
    acc(1'b1, 8'h06, 8'h01);
    storm(30, 256);
    $display("test storm limit done");
    summarize();
  end
endmodule
